// File: verilog/irq_bank_pkg.sv
// Constants, field positions and carrier types of the interrupt flag bank
package irq_bank_pkg;

  localparam int DATA_W        = 16;
  localparam int ADDR_W        = 4;
  localparam int SLOT_W        = 3;
  localparam int NUM_FLAG_REGS = 7;

  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] BIT_ONE   = 16'h0001;

  // Register addresses, one 16-bit register per address
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_0   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_1   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_3   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_4   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_5   = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_6   = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_7   = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLES_0 = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS    = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK      = 4'ha;

  // Slots of the flag bank, in address order
  localparam logic [SLOT_W-1:0] SLOT_FLAGS_0 = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_FLAGS_1 = 3'h1;
  localparam logic [SLOT_W-1:0] SLOT_FLAGS_3 = 3'h2;
  localparam logic [SLOT_W-1:0] SLOT_FLAGS_4 = 3'h3;
  localparam logic [SLOT_W-1:0] SLOT_FLAGS_5 = 3'h4;
  localparam logic [SLOT_W-1:0] SLOT_FLAGS_6 = 3'h5;
  localparam logic [SLOT_W-1:0] SLOT_FLAGS_7 = 3'h6;

  // First flag register and first enable register share one layout
  localparam int ADC_COMPLETE_ENABLE_BIT = 13;
  localparam int SERIAL_TX_ENABLE_BIT    = 12;
  localparam int SERIAL_RX_ENABLE_BIT    = 11;
  localparam int SPI_EVENT_ENABLE_BIT    = 10;
  localparam int SPI_ERROR_ENABLE_BIT    = 9;
  localparam int TIMER3_IRQ_ENABLE_BIT   = 8;
  localparam int TIMER2_IRQ_ENABLE_BIT   = 7;
  localparam int COMPARE2_ENABLE_BIT     = 6;
  localparam int CAPTURE2_ENABLE_BIT     = 5;
  localparam int TIMER1_IRQ_ENABLE_BIT   = 3;
  localparam int COMPARE1_ENABLE_BIT     = 2;
  localparam int CAPTURE1_FLAG_BIT       = 1;
  localparam int EXT_PIN0_FLAG_BIT       = 0;

  localparam int EXT_PIN2_FLAG_BIT       = 13;
  localparam int EXT_PIN1_FLAG_BIT       = 4;
  localparam int PIN_CHANGE_FLAG_BIT     = 3;
  localparam int COMPARATOR1_FLAG_BIT    = 2;
  localparam int I2C_MASTER_FLAG_BIT     = 1;
  localparam int I2C_SLAVE_FLAG_BIT      = 0;
  localparam int PWM_SPECIAL_MATCH_BIT   = 9;
  localparam int SERIAL_ERROR_FLAG_BIT   = 1;
  localparam int PWM_GEN2_FLAG_BIT       = 15;
  localparam int PWM_GEN1_FLAG_BIT       = 14;
  localparam int ADC_PAIR1_DONE_BIT      = 15;
  localparam int ADC_PAIR0_DONE_BIT      = 14;
  localparam int COMPARATOR4_FLAG_BIT    = 9;
  localparam int COMPARATOR3_FLAG_BIT    = 8;
  localparam int COMPARATOR2_FLAG_BIT    = 7;
  localparam int PWM_GEN4_FLAG_BIT       = 1;
  localparam int PWM_GEN3_FLAG_BIT       = 0;
  localparam int ADC_PAIR_HIGH_DONE_BIT  = 4;

  // Implemented-bit masks; every other position is held at zero
  localparam logic [DATA_W-1:0] IMPL_FIRST = // [RULE1] [RULE9] [RULE10]
    (BIT_ONE << ADC_COMPLETE_ENABLE_BIT) | (BIT_ONE << SERIAL_TX_ENABLE_BIT) |
    (BIT_ONE << SERIAL_RX_ENABLE_BIT) | (BIT_ONE << SPI_EVENT_ENABLE_BIT) |
    (BIT_ONE << SPI_ERROR_ENABLE_BIT) | (BIT_ONE << TIMER3_IRQ_ENABLE_BIT) |
    (BIT_ONE << TIMER2_IRQ_ENABLE_BIT) | (BIT_ONE << COMPARE2_ENABLE_BIT) |
    (BIT_ONE << CAPTURE2_ENABLE_BIT) | (BIT_ONE << TIMER1_IRQ_ENABLE_BIT) |
    (BIT_ONE << COMPARE1_ENABLE_BIT) | (BIT_ONE << CAPTURE1_FLAG_BIT) |
    (BIT_ONE << EXT_PIN0_FLAG_BIT);
  localparam logic [DATA_W-1:0] IMPL_FLAGS_1 = // [RULE2] [RULE3]
    (BIT_ONE << EXT_PIN2_FLAG_BIT) | (BIT_ONE << EXT_PIN1_FLAG_BIT) |
    (BIT_ONE << PIN_CHANGE_FLAG_BIT) | (BIT_ONE << COMPARATOR1_FLAG_BIT) |
    (BIT_ONE << I2C_MASTER_FLAG_BIT) | (BIT_ONE << I2C_SLAVE_FLAG_BIT);
  localparam logic [DATA_W-1:0] IMPL_FLAGS_3 =
    BIT_ONE << PWM_SPECIAL_MATCH_BIT; // [RULE4]
  localparam logic [DATA_W-1:0] IMPL_FLAGS_4 =
    BIT_ONE << SERIAL_ERROR_FLAG_BIT; // [RULE5]
  localparam logic [DATA_W-1:0] IMPL_FLAGS_5 = // [RULE6]
    (BIT_ONE << PWM_GEN2_FLAG_BIT) | (BIT_ONE << PWM_GEN1_FLAG_BIT);
  localparam logic [DATA_W-1:0] IMPL_FLAGS_6 = // [RULE7]
    (BIT_ONE << ADC_PAIR1_DONE_BIT) | (BIT_ONE << ADC_PAIR0_DONE_BIT) |
    (BIT_ONE << COMPARATOR4_FLAG_BIT) | (BIT_ONE << COMPARATOR3_FLAG_BIT) |
    (BIT_ONE << COMPARATOR2_FLAG_BIT) | (BIT_ONE << PWM_GEN4_FLAG_BIT) |
    (BIT_ONE << PWM_GEN3_FLAG_BIT);
  localparam logic [DATA_W-1:0] IMPL_FLAGS_7 = // [RULE8]
    (BIT_ONE << (ADC_PAIR_HIGH_DONE_BIT + 1)) - BIT_ONE;

  typedef logic [NUM_FLAG_REGS-1:0][DATA_W-1:0] flag_bank_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;

  typedef struct packed {
    logic              hit;
    logic [SLOT_W-1:0] slot;
  } slot_hit_s;

  typedef struct packed {
    flag_bank_t               flags;
    logic [DATA_W-1:0]        enables;
    logic [NUM_FLAG_REGS-1:0] evt_status;
    logic [NUM_FLAG_REGS-1:0] evt_mask;
    logic [DATA_W-1:0]        rdata;
  } bank_state_s;

  localparam bank_state_s STATE_RESET = '0;

endpackage

// File: verilog/irq_flag_bank.sv
// Interrupt flag and first enable register bank with event interrupt
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
//
// What this block does
// RULE1: Capture1 flag bit 1, pin0 flag bit 0
// RULE2: Pin2 flag bit 13; bits 15-14, 12-5 zero
// RULE3: Pin1, change, comparator1, I2C master/slave at 4..0
// RULE4: PWM special match flag bit 9, rest zero
// RULE5: Serial error flag bit 1, rest zero
// RULE6: PWM gen2 bit 15, gen1 bit 14
// RULE7: ADC pairs, comparators, PWM gens in sixth register
// RULE8: ADC pairs 6..2 done at bits 4..0
// RULE9: Enable bits 13..8: ADC, serial, SPI, timer3
// RULE10: Enable bits 7..0: timer2, compare, capture, pin0
// RULE11: Flag reads one once request occurred
// RULE12: Enable one permits, zero blocks request
// RULE13: Unimplemented bits ignore writes, read zero
// RULE14: Implemented bits read/write, reset to zero
// RULE15: Event sets flag until software writes zero
// RULE16: Request only while flag and enable set
module irq_flag_bank (
  input  wire logic                           mclk_in,
  input  wire logic                           srst_in,
  input  wire irq_bank_pkg::bus_req_s         bus_in,
  input  wire irq_bank_pkg::flag_bank_t       events_in,
  output logic [irq_bank_pkg::DATA_W-1:0]     rdata_out,
  output irq_bank_pkg::flag_bank_t            flags_out,
  output logic [irq_bank_pkg::DATA_W-1:0]     enables_out,
  output logic [irq_bank_pkg::DATA_W-1:0]     req_out,
  output logic                                irq_out
);
  import irq_bank_pkg::*;

  bank_state_s              st_q;
  bank_state_s              st_d;
  slot_hit_s                acc_hit;
  logic [NUM_FLAG_REGS-1:0] evt_grp;
  logic [DATA_W-1:0]        evt_bits;
  logic                     wr_flag;
  logic                     rd_status;

  function automatic logic [DATA_W-1:0] impl_mask(input logic [SLOT_W-1:0] s);
    case (s)
      SLOT_FLAGS_0: impl_mask = IMPL_FIRST;
      SLOT_FLAGS_1: impl_mask = IMPL_FLAGS_1;
      SLOT_FLAGS_3: impl_mask = IMPL_FLAGS_3;
      SLOT_FLAGS_4: impl_mask = IMPL_FLAGS_4;
      SLOT_FLAGS_5: impl_mask = IMPL_FLAGS_5;
      SLOT_FLAGS_6: impl_mask = IMPL_FLAGS_6;
      SLOT_FLAGS_7: impl_mask = IMPL_FLAGS_7;
      default:      impl_mask = REG_RESET;
    endcase
  endfunction

  function automatic slot_hit_s addr_to_slot(input logic [ADDR_W-1:0] a);
    addr_to_slot = '0;
    addr_to_slot.hit = 1'b1;
    case (a)
      ADDR_IRQ_FLAGS_0: addr_to_slot.slot = SLOT_FLAGS_0;
      ADDR_IRQ_FLAGS_1: addr_to_slot.slot = SLOT_FLAGS_1;
      ADDR_IRQ_FLAGS_3: addr_to_slot.slot = SLOT_FLAGS_3;
      ADDR_IRQ_FLAGS_4: addr_to_slot.slot = SLOT_FLAGS_4;
      ADDR_IRQ_FLAGS_5: addr_to_slot.slot = SLOT_FLAGS_5;
      ADDR_IRQ_FLAGS_6: addr_to_slot.slot = SLOT_FLAGS_6;
      ADDR_IRQ_FLAGS_7: addr_to_slot.slot = SLOT_FLAGS_7;
      default:          addr_to_slot.hit  = 1'b0;
    endcase
  endfunction

  always_comb begin
    st_d      = st_q;
    acc_hit   = addr_to_slot(bus_in.addr);
    evt_grp   = '0;
    evt_bits  = REG_RESET;
    wr_flag   = 1'b0;
    rd_status = bus_in.rd && (bus_in.addr == ADDR_EVT_STATUS);
    // Read data only stand in the cycle after the read strobe
    st_d.rdata = REG_RESET;

    for (int s = 0; s < NUM_FLAG_REGS; s++) begin
      wr_flag  = bus_in.wr && acc_hit.hit &&
                 (acc_hit.slot == SLOT_W'(s));
      evt_bits = events_in[s] & impl_mask(SLOT_W'(s)); // [RULE13]
      evt_grp[s] = |evt_bits;
      // Software write stores zeros and ones alike
      if (wr_flag) begin
        st_d.flags[s] = bus_in.wdata & impl_mask(SLOT_W'(s)); // [RULE14]
      end
      // Event ORed after the write, so a set never loses to a clear
      st_d.flags[s] = st_d.flags[s] | evt_bits; // [RULE15] [RULE11]
    end

    if (bus_in.wr && (bus_in.addr == ADDR_IRQ_ENABLES_0)) begin
      st_d.enables = bus_in.wdata & IMPL_FIRST; // [RULE9] [RULE10]
    end
    if (bus_in.wr && (bus_in.addr == ADDR_EVT_MASK)) begin
      st_d.evt_mask = bus_in.wdata[NUM_FLAG_REGS-1:0];
    end

    // Read clears the sticky status; a same-cycle event still lands
    if (rd_status) begin
      st_d.evt_status = '0;
    end
    st_d.evt_status = st_d.evt_status | evt_grp;

    if (bus_in.rd) begin
      if (acc_hit.hit) begin
        st_d.rdata = st_q.flags[acc_hit.slot]; // [RULE11]
      end else begin
        case (bus_in.addr)
          ADDR_IRQ_ENABLES_0: begin
            st_d.rdata = st_q.enables;
          end
          ADDR_EVT_STATUS: begin
            st_d.rdata = {{(DATA_W-NUM_FLAG_REGS){1'b0}}, st_q.evt_status};
          end
          ADDR_EVT_MASK: begin
            st_d.rdata = {{(DATA_W-NUM_FLAG_REGS){1'b0}}, st_q.evt_mask};
          end
          default: begin
            st_d.rdata = REG_RESET;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_q <= STATE_RESET; // [RULE14]
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out   = st_q.rdata;
  assign flags_out   = st_q.flags;
  assign enables_out = st_q.enables;
  // Only the first flag register has its enables here; the others leave
  // the block as raw flags and are gated by the enables kept elsewhere
  assign req_out     = st_q.flags[SLOT_FLAGS_0] &
                       st_q.enables; // [RULE12] [RULE16]
  assign irq_out     = |(st_q.evt_status & st_q.evt_mask);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  logic [DATA_W-1:0] chk_first_evt;
  assign chk_first_evt = events_in[SLOT_FLAGS_0] & IMPL_FIRST;

  // The default disable would switch this check off during reset itself
  property p_reset_clears;
    @(posedge mclk_in) disable iff (1'b0) srst_in |=>
      (flags_out == '0) && (enables_out == '0) && !irq_out;
  endproperty
  a_reset_clears: assert property (p_reset_clears) // [RULE14]
    else $error("bank not cleared by reset");

  property p_capture1_pos;
    events_in[SLOT_FLAGS_0][CAPTURE1_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_0][CAPTURE1_FLAG_BIT];
  endproperty
  a_capture1_pos: assert property (p_capture1_pos) // [RULE1]
    else $error("capture1 event did not set its flag");

  property p_pin2_pos;
    events_in[SLOT_FLAGS_1][EXT_PIN2_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_1][EXT_PIN2_FLAG_BIT];
  endproperty
  a_pin2_pos: assert property (p_pin2_pos) // [RULE2]
    else $error("pin2 event did not set its flag");

  property p_i2c_master_pos;
    events_in[SLOT_FLAGS_1][I2C_MASTER_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_1][I2C_MASTER_FLAG_BIT];
  endproperty
  a_i2c_master_pos: assert property (p_i2c_master_pos) // [RULE3]
    else $error("i2c master event did not set its flag");

  property p_special_match_pos;
    events_in[SLOT_FLAGS_3][PWM_SPECIAL_MATCH_BIT] |=>
      flags_out[SLOT_FLAGS_3][PWM_SPECIAL_MATCH_BIT];
  endproperty
  a_special_match_pos: assert property (p_special_match_pos) // [RULE4]
    else $error("special match event did not set its flag");

  property p_unimpl_zero;
    ((flags_out[SLOT_FLAGS_0] & ~IMPL_FIRST) == '0) &&
    ((flags_out[SLOT_FLAGS_1] & ~IMPL_FLAGS_1) == '0) &&
    ((flags_out[SLOT_FLAGS_3] & ~IMPL_FLAGS_3) == '0) &&
    ((flags_out[SLOT_FLAGS_4] & ~IMPL_FLAGS_4) == '0) &&
    ((flags_out[SLOT_FLAGS_5] & ~IMPL_FLAGS_5) == '0) &&
    ((flags_out[SLOT_FLAGS_6] & ~IMPL_FLAGS_6) == '0) &&
    ((flags_out[SLOT_FLAGS_7] & ~IMPL_FLAGS_7) == '0) &&
    ((enables_out & ~IMPL_FIRST) == '0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // [RULE13]
    else $error("unimplemented bit holds a one");

  property p_fifth_write;
    (bus_in.wr && bus_in.addr == ADDR_IRQ_FLAGS_5 &&
     events_in[SLOT_FLAGS_5] == '0) |=>
      flags_out[SLOT_FLAGS_5] == ($past(bus_in.wdata) & IMPL_FLAGS_5);
  endproperty
  a_fifth_write: assert property (p_fifth_write) // [RULE6]
    else $error("fifth flag register write not stored");

  property p_sixth_write;
    (bus_in.wr && bus_in.addr == ADDR_IRQ_FLAGS_6 &&
     events_in[SLOT_FLAGS_6] == '0) |=>
      flags_out[SLOT_FLAGS_6] == ($past(bus_in.wdata) & IMPL_FLAGS_6);
  endproperty
  a_sixth_write: assert property (p_sixth_write) // [RULE7]
    else $error("sixth flag register write not stored");

  property p_adc_high_done;
    events_in[SLOT_FLAGS_7][ADC_PAIR_HIGH_DONE_BIT] |=>
      flags_out[SLOT_FLAGS_7][ADC_PAIR_HIGH_DONE_BIT];
  endproperty
  a_adc_high_done: assert property (p_adc_high_done) // [RULE8]
    else $error("adc pair 6 done did not set its flag");

  property p_serial_err_read;
    (events_in[SLOT_FLAGS_4][SERIAL_ERROR_FLAG_BIT] && !bus_in.wr)
      ##1 (bus_in.rd && bus_in.addr == ADDR_IRQ_FLAGS_4) |=>
      rdata_out[SERIAL_ERROR_FLAG_BIT];
  endproperty
  a_serial_err_read: assert property (p_serial_err_read) // [RULE5] [RULE11]
    else $error("serial error flag not read back");

  property p_enable_write;
    (bus_in.wr && bus_in.addr == ADDR_IRQ_ENABLES_0) |=>
      enables_out == ($past(bus_in.wdata) & IMPL_FIRST);
  endproperty
  a_enable_write: assert property (p_enable_write) // [RULE9] [RULE10]
    else $error("enable register write not stored");

  sequence s_enables_cleared;
    bus_in.wr && bus_in.addr == ADDR_IRQ_ENABLES_0 && bus_in.wdata == '0;
  endsequence

  sequence s_no_enable_write;
    !(bus_in.wr && bus_in.addr == ADDR_IRQ_ENABLES_0);
  endsequence

  property p_blocked_req;
    s_enables_cleared ##1 s_no_enable_write |=> req_out == '0;
  endproperty
  a_blocked_req: assert property (p_blocked_req) // [RULE12]
    else $error("request passed a cleared enable");

  property p_req_follows;
    (chk_first_evt != '0) ##0 s_no_enable_write |=>
      ((req_out & $past(chk_first_evt)) ==
       ($past(enables_out) & $past(chk_first_evt)));
  endproperty
  a_req_follows: assert property (p_req_follows) // [RULE16]
    else $error("request does not follow flag and enable");

  sequence s_flag_write_zero;
    bus_in.wr && bus_in.addr == ADDR_IRQ_FLAGS_0 && bus_in.wdata == '0 &&
    chk_first_evt == '0;
  endsequence

  sequence s_flag_stays_clear;
    (flags_out[SLOT_FLAGS_0] == '0) && (req_out == '0);
  endsequence

  property p_write_zero_clears;
    s_flag_write_zero |=> s_flag_stays_clear;
  endproperty
  a_write_zero_clears: assert property (p_write_zero_clears) // [RULE15]
    else $error("write of zero did not clear the flags");

  property p_set_beats_clear;
    (bus_in.wr && bus_in.addr == ADDR_IRQ_FLAGS_0 &&
     chk_first_evt != '0) |=>
      ((flags_out[SLOT_FLAGS_0] & $past(chk_first_evt)) ==
       $past(chk_first_evt));
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // [RULE15]
    else $error("event lost against a software write");

  property p_flag_holds;
    (flags_out[SLOT_FLAGS_0][EXT_PIN0_FLAG_BIT] &&
     !(bus_in.wr && bus_in.addr == ADDR_IRQ_FLAGS_0)) |=>
      flags_out[SLOT_FLAGS_0][EXT_PIN0_FLAG_BIT] [*1];
  endproperty
  a_flag_holds: assert property (p_flag_holds) // [RULE15]
    else $error("pin0 flag dropped without a write");

  property p_status_irq;
    (events_in[SLOT_FLAGS_0] & IMPL_FIRST) != '0 &&
    st_q.evt_mask[SLOT_FLAGS_0] &&
    !(bus_in.wr && bus_in.addr == ADDR_EVT_MASK) |=> irq_out;
  endproperty
  a_status_irq: assert property (p_status_irq)
    else $error("masked-in event did not raise the interrupt");

  property p_status_read_clears;
    (bus_in.rd && bus_in.addr == ADDR_EVT_STATUS && evt_grp == '0) |=>
      (rdata_out[NUM_FLAG_REGS-1:0] == $past(st_q.evt_status)) &&
      (st_q.evt_status == '0) && !irq_out;
  endproperty
  a_status_read_clears: assert property (p_status_read_clears)
    else $error("status read did not return and clear");

  property p_rdata_idle;
    !bus_in.rd |=> rdata_out == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data present without a read");

  property p_ext_pin0_pos;
    events_in[SLOT_FLAGS_0][EXT_PIN0_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_0][EXT_PIN0_FLAG_BIT];
  endproperty
  a_ext_pin0_pos: assert property (p_ext_pin0_pos) // [RULE1]
    else $error("pin0 event did not set its flag");

  property p_i2c_slave_pos;
    events_in[SLOT_FLAGS_1][I2C_SLAVE_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_1][I2C_SLAVE_FLAG_BIT];
  endproperty
  a_i2c_slave_pos: assert property (p_i2c_slave_pos) // [RULE3]
    else $error("i2c slave event did not set its flag");

  property p_serial_err_pos;
    events_in[SLOT_FLAGS_4][SERIAL_ERROR_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_4][SERIAL_ERROR_FLAG_BIT];
  endproperty
  a_serial_err_pos: assert property (p_serial_err_pos) // [RULE5]
    else $error("serial error event did not set its flag");

  property p_pwm_gen2_pos;
    events_in[SLOT_FLAGS_5][PWM_GEN2_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_5][PWM_GEN2_FLAG_BIT];
  endproperty
  a_pwm_gen2_pos: assert property (p_pwm_gen2_pos) // [RULE6]
    else $error("pwm gen2 event did not set its flag");

  property p_comparator2_pos;
    events_in[SLOT_FLAGS_6][COMPARATOR2_FLAG_BIT] |=>
      flags_out[SLOT_FLAGS_6][COMPARATOR2_FLAG_BIT];
  endproperty
  a_comparator2_pos: assert property (p_comparator2_pos) // [RULE7]
    else $error("comparator2 event did not set its flag");

  property p_first_write;
    (bus_in.wr && bus_in.addr == ADDR_IRQ_FLAGS_0 &&
     chk_first_evt == '0) |=>
      flags_out[SLOT_FLAGS_0] == ($past(bus_in.wdata) & IMPL_FIRST);
  endproperty
  a_first_write: assert property (p_first_write) // [RULE14]
    else $error("first flag register write not stored");

  property p_unmapped_write;
    (bus_in.wr && !acc_hit.hit && bus_in.addr != ADDR_IRQ_ENABLES_0 &&
     events_in == '0) |=>
      $stable(flags_out) && $stable(enables_out);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) // [RULE13]
    else $error("write elsewhere changed a flag or enable");

  // Status is sticky: only a status read or a mask write may drop the line
  property p_status_sticky;
    (irq_out && !(bus_in.rd && bus_in.addr == ADDR_EVT_STATUS) &&
     !(bus_in.wr && bus_in.addr == ADDR_EVT_MASK)) |=> irq_out;
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("interrupt dropped without a status read");

  property p_sixth_read;
    (bus_in.rd && bus_in.addr == ADDR_IRQ_FLAGS_6) |=>
      rdata_out == $past(flags_out[SLOT_FLAGS_6]);
  endproperty
  a_sixth_read: assert property (p_sixth_read) // [RULE7] [RULE11]
    else $error("sixth flag register read wrong");

endmodule

// File: bench/event_source.sv
// Peripheral event source model driving the flag bank's event inputs
`timescale 1ns/10ps
module event_source (
  input  wire logic               mclk_in,
  output irq_bank_pkg::flag_bank_t events_out
);
  import irq_bank_pkg::*;

  initial events_out = '0;

  // Holds a request for n cycles: n=1 models a strobe, more a slow level
  task automatic pulse(input logic [SLOT_W-1:0] slot,
                       input logic [DATA_W-1:0] bits, input int n);
    @(posedge mclk_in);
    events_out[slot] <= bits;
    repeat (n) @(posedge mclk_in);
    events_out <= '0;
    #1;
  endtask
endmodule

// File: bench/test_irq_flag_bank.sv
// Self-checking testbench of the interrupt flag and enable bank
`timescale 1ns/10ps
module test_irq_flag_bank;
  import irq_bank_pkg::*;

  logic                    mclk_in;
  logic                    srst_in;
  bus_req_s                bus_in;
  flag_bank_t              events_in;
  logic [DATA_W-1:0]       rdata_out;
  flag_bank_t              flags_out;
  logic [DATA_W-1:0]       enables_out;
  logic [DATA_W-1:0]       req_out;
  logic                    irq_out;
  int                      bad_count;
  int                      checked;
  logic [DATA_W-1:0]       rd_v;
  // Index 0..6 are the flag slots, 7 is the first enable register
  logic [ADDR_W-1:0]       addr_tab [8] = '{4'h0, 4'h1, 4'h3, 4'h4,
                                            4'h5, 4'h6, 4'h7, 4'h8};
  logic [DATA_W-1:0]       mask_tab [8] = '{16'h3fef, 16'h201f, 16'h0200,
                                            16'h0002, 16'hc000, 16'hc383,
                                            16'h001f, 16'h3fef};

  irq_flag_bank u_irq_flag_bank (
    .mclk_in     (mclk_in),
    .srst_in     (srst_in),
    .bus_in      (bus_in),
    .events_in   (events_in),
    .rdata_out   (rdata_out),
    .flags_out   (flags_out),
    .enables_out (enables_out),
    .req_out     (req_out),
    .irq_out     (irq_out)
  );

  event_source u_event_source (
    .mclk_in    (mclk_in),
    .events_out (events_in)
  );

  initial mclk_in = 1'b0;
  always #2.5 mclk_in = ~mclk_in;

  task automatic check(input string what, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d);
    @(posedge mclk_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    bus_in.wr <= 1'b0;
    #1;
  endtask

  task automatic bus_read(input logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
    @(posedge mclk_in);
    bus_in <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    bus_in.rd <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      bus_read(addr_tab[i], rd_v);
      check("reset value", rd_v, 16'h0000);
    end
    check("reset enables", enables_out, 16'h0000);
    check("reset req", req_out, 16'h0000);
    check("reset irq", {15'h0000, irq_out}, 16'h0000);
  endtask

  // All ones shows the layout; unimplemented positions must stay zero
  task automatic t_layout();
    for (int i = 0; i < 8; i++) begin
      bus_write(addr_tab[i], 16'hffff);
      bus_read(addr_tab[i], rd_v);
      check("layout read", rd_v,
            mask_tab[i]);
      check("layout out", (i < 7) ? flags_out[i] : enables_out,
            mask_tab[i]);
      bus_write(addr_tab[i], 16'h0000);
      bus_read(addr_tab[i], rd_v);
      check("cleared read", rd_v, 16'h0000);
    end
  endtask

  task automatic t_unmapped();
    bus_write(4'h2, 16'hffff);
    bus_write(4'hb, 16'hffff);
    bus_read(4'h2, rd_v);
    check("unmapped read", rd_v, 16'h0000);
    bus_read(4'hf, rd_v);
    check("unmapped read", rd_v, 16'h0000);
    check("no alias", flags_out[0] | flags_out[1] | enables_out,
          16'h0000);
  endtask

  task automatic t_events();
    for (int s = 0; s < 7; s++) begin
      u_event_source.pulse(s[SLOT_W-1:0], 16'hffff, 1 + s % 2);
      repeat (3) @(posedge mclk_in);
      #1;
      check("event flag", flags_out[s], mask_tab[s]);
      bus_write(addr_tab[s], 16'h0000);
      check("flag cleared", flags_out[s], 16'h0000);
    end
    // An event landing with a clearing write must not be lost
    fork
      bus_write(4'h0, 16'h0000);
      u_event_source.pulse(3'h0, 16'h0002, 1);
    join
    check("event beats clear", flags_out[0], 16'h0002);
    bus_write(4'h0, 16'h0000);
  endtask

  task automatic t_request();
    bus_write(4'h8, 16'h3fef);
    u_event_source.pulse(3'h0, 16'h0005, 1);
    check("req both", req_out, 16'h0005);
    bus_write(4'h8, 16'h0004);
    check("req masked", req_out, 16'h0004);
    bus_write(4'h0, 16'h0000);
    check("req no flag", req_out, 16'h0000);
    bus_write(4'h8, 16'h0000);
  endtask

  task automatic t_irq();
    bus_read(4'h9, rd_v);
    check("status sticky", rd_v, 16'h007f);
    bus_write(4'ha, 16'h0001);
    // Read strobe right after the event edge sees the flag already set
    fork
      u_event_source.pulse(3'h3, 16'h0002, 1);
      begin
        @(posedge mclk_in);
        bus_read(4'h4, rd_v);
      end
    join
    check("serial error read", rd_v, 16'h0002);
    check("irq masked", {15'h0000, irq_out}, 16'h0000);
    bus_write(4'ha, 16'h0008);
    check("irq unmasked", {15'h0000, irq_out}, 16'h0001);
    bus_read(4'ha, rd_v);
    check("mask read", rd_v, 16'h0008);
    bus_read(4'h9, rd_v);
    check("status read", rd_v, 16'h0008);
    check("irq after read", {15'h0000, irq_out}, 16'h0000);
    bus_read(4'h9, rd_v);
    check("status cleared", rd_v, 16'h0000);
    bus_write(4'h4, 16'h0000);
  endtask

  // Reset in mid-run with flags, enables, mask and status all busy
  task automatic t_rerun_reset();
    bus_write(4'ha, 16'h007f);
    bus_write(4'h8, 16'hffff);
    u_event_source.pulse(3'h0, 16'hffff, 1);
    check("irq before reset", {15'h0000, irq_out}, 16'h0001);
    check("req before reset", req_out, 16'h3fef);
    @(posedge mclk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_reset();
  endtask

  initial begin
    bad_count = 0;
    checked = 0;
    srst_in = 1'b1;
    bus_in = '0;
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_reset();
    t_layout();
    t_unmapped();
    t_events();
    t_request();
    t_irq();
    t_rerun_reset();
    wrap_up();
  end

  // The whole sequence needs a few hundred cycles
  initial begin
    #50000;
    bad_count++;
    wrap_up();
  end
endmodule
